// ### pkg/ufb_pkg.sv
/*
  Shared constants and types for the full-speed USB device bus front end:
  APB register map, field positions, reset values, timing and line states.
  Assumes a 25 MHz system clock and a 32-bit APB master.
*/
package ufb_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 12;
  // register byte addresses
  localparam logic [11:0] ADDR_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_PULLUP = 12'h004;
  localparam logic [11:0] ADDR_FORCE_VAL = 12'h008;
  localparam logic [11:0] ADDR_TASK = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_EVENTS = 12'h014;
  localparam logic [11:0] ADDR_DEV_ADDR = 12'h018;
  localparam logic [11:0] ADDR_EP_ENABLE = 12'h01c;
  localparam logic [11:0] ADDR_EP_INFO = 12'h020;
  // task register bits
  localparam int unsigned TASK_FORCE_BIT = 0;
  localparam int unsigned TASK_RELEASE_BIT = 1;
  // event register bits (write one to clear)
  localparam int unsigned EV_BUS_RESET = 0;
  localparam int unsigned EV_ACCESS_FAULT = 1;
  localparam int unsigned EV_PWR_READY = 2;
  localparam int unsigned EV_BUS_READY = 3;
  localparam int unsigned EV_W = 4;
  // endpoint enable: bits 0..8 IN (0 control, 1..7 bulk, 8 iso), 16..24 OUT
  localparam int unsigned EP_PER_DIR = 9;
  localparam int unsigned EP_OUT_BASE = 16;
  localparam int unsigned EP_ISO_IDX = 8;
  localparam logic [31:0] EP_ENABLE_RST = 32'h0001_0001;
  localparam logic [31:0] EP_CTRL_MASK = 32'h0001_0001;
  // endpoint buffer limits
  localparam logic [10:0] BULK_BUF_BYTES = 11'd64;
  localparam logic [10:0] ISO_BUF_BYTES = 11'd1023;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // timing
  localparam int unsigned RESET_DET_NS = 2500;
  localparam int unsigned RESET_DET_CYC =
    (RESET_DET_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PWR_SETTLE_NS = 10000;
  localparam int unsigned PWR_SETTLE_CYC =
    (PWR_SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned BIT_RATE_MBPS = 12;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_K = 2'b01,
    LS_J = 2'b10,
    LS_SE1 = 2'b11
  } ufb_line_type;

  // forced line values: resume uses hardware-timed K
  typedef enum logic [1:0] {
    FV_RESUME = 2'b00,
    FV_J = 2'b01,
    FV_K = 2'b10
  } ufb_force_type;

  localparam int unsigned RESUME_NS = 10000;
  localparam int unsigned RESUME_CYC =
    (RESUME_NS * (CLK_HZ / 1000000)) / 1000;
endpackage

// ### pkg/ufb_sync_if.sv
/*
  Carrier between the front end and its line synchroniser.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface ufb_sync_if;
  logic dp_raw;
  logic dm_raw;
  logic [1:0] state;
  modport src (output dp_raw, output dm_raw, input state);
  modport sync (input dp_raw, input dm_raw, output state);
endinterface
`default_nettype wire

// ### src/ufb_line_sync.sv
/*
  Two-stage synchroniser for D+ and D-, giving the line pair {dp, dm}.
  Assumes clk_sys and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ufb_line_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // lines
  ufb_sync_if.sync lines
);
  import ufb_pkg::*;
  logic [1:0] meta_r;
  logic [1:0] stable_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_r <= 2'h0;
      stable_r <= 2'h0;
    end else begin
      meta_r <= {lines.dp_raw, lines.dm_raw};
      stable_r <= meta_r;
    end
  end

  assign lines.state = stable_r;
endmodule
`default_nettype wire

// ### src/ufb_frontend.sv
/*
  Full-speed USB device bus front end: line state decode, transceiver
  power, D+ pull-up control, line forcing, bus reset detection and the
  endpoint enable map, with an APB register slave.
  Assumes pins sampled on clk_sys; host pull-downs outside.
*/
// The APB interface to the registers and the address map are this design's own decisions.
// How it works
// - D+ high, D- low decodes as J
// - D+ low, D- high decodes as K
// - both low SE0, both high SE1
// - idle bus counts as J state
// - pins, pull-up live only with supply and enable
// - transceiver power follows enable directly
// - pull-up follows software pull-up register
// - traffic and bus reset events only while pull-up enabled
// - no bus reset event while pull-up off
// - pull-up off after chip reset
// - pull-up access while disabled raises fault
// - pull-up strength adjusted by hardware activity
// - force task drives lines to force value
// - release task stops forcing lines
// - full speed only, ignore higher speed chirp
// - two control, fourteen bulk, two iso endpoints
// - bulk 64 bytes, iso up to 1023
// - iso endpoints double buffered
// - long SE0 raises reset, clears non-control endpoints, address
// - ignore traffic until first bus reset
// - force value captured only at force task
`timescale 1ns/1ps
`default_nettype none
module ufb_frontend #(
  parameter int unsigned RESET_CYC = ufb_pkg::RESET_DET_CYC,
  parameter int unsigned SETTLE_CYC = ufb_pkg::PWR_SETTLE_CYC,
  parameter int unsigned RESUME_CYCLES = ufb_pkg::RESUME_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ufb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply
  input wire logic vbus_valid,
  // usb lines
  input wire logic dp_in,
  input wire logic dm_in,
  output logic dp_out,
  output logic dm_out,
  output logic dpdm_oe,
  // analog control
  output logic phy_power_on,
  output logic pullup_on,
  output logic pullup_strong,
  // status toward the packet engine
  output logic traffic_enable,
  output logic [31:0] ep_enable,
  output logic [6:0] device_address,
  output logic iso_in_bank,
  output logic iso_out_bank,
  output logic access_fault_event
);
  import ufb_pkg::*;

  ufb_sync_if lines ();
  logic [1:0] line_now;
  ufb_line_type bus_state;

  assign lines.dp_raw = dp_in;
  assign lines.dm_raw = dm_in;

  ufb_line_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .lines(lines)
  );
  assign line_now = lines.state;

  function automatic ufb_line_type decode_line(input logic [1:0] dpdm);
    ufb_line_type s;
    s = LS_SE0;
    unique case (dpdm)
      2'b10: s = LS_J;
      2'b01: s = LS_K;
      2'b00: s = LS_SE0;
      2'b11: s = LS_SE1;
    endcase
    return s;
  endfunction

  assign bus_state = decode_line(line_now);

  // apb decode
  logic wr_acc;
  logic mapped;
  assign wr_acc = psel && penable && pwrite;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return a == ADDR_ENABLE || a == ADDR_PULLUP || a == ADDR_FORCE_VAL ||
      a == ADDR_TASK || a == ADDR_STATUS || a == ADDR_EVENTS ||
      a == ADDR_DEV_ADDR || a == ADDR_EP_ENABLE || a == ADDR_EP_INFO;
  endfunction
  assign mapped = addr_hit(paddr);

  // controller enable and transceiver power
  logic enable_r;
  logic live;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      enable_r <= 1'b0;
    end else if (wr_acc && paddr == ADDR_ENABLE) begin
      enable_r <= pwdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phy_power_on <= 1'b0;
    end else begin
      phy_power_on <= enable_r;
    end
  end
  assign live = vbus_valid && enable_r;

  // power settle counter gives the transceiver-ready event
  logic [CNT_W-1:0] settle_cnt_r;
  logic pwr_ready_r;
  always_ff @(posedge clk_sys) begin
    if (!nrst || !live) begin
      settle_cnt_r <= '0;
      pwr_ready_r <= 1'b0;
    end else if (settle_cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
      pwr_ready_r <= 1'b1;
    end else begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end

  // software pull-up; software sequencing is its own concern
  logic pullup_r;
  logic pullup_acc;
  assign pullup_acc = psel && penable && paddr == ADDR_PULLUP;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pullup_r <= 1'b0;
    end else if (!enable_r) begin
      pullup_r <= 1'b0;
    end else if (wr_acc && paddr == ADDR_PULLUP) begin
      pullup_r <= pwdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      access_fault_event <= 1'b0;
    end else begin
      access_fault_event <= pullup_acc && !enable_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pullup_on <= 1'b0;
    end else begin
      pullup_on <= pullup_r && live;
    end
  end

  logic active;
  assign active = pullup_r && live;

  // reset detection; suppressed while pull-up off
  logic [CNT_W-1:0] se0_cnt_r;
  logic reset_hit;
  always_ff @(posedge clk_sys) begin
    if (!nrst || !active || bus_state != LS_SE0) begin
      se0_cnt_r <= '0;
    end else if (se0_cnt_r != CNT_W'(RESET_CYC)) begin
      se0_cnt_r <= se0_cnt_r + 1'b1;
    end
  end
  assign reset_hit = active && bus_state == LS_SE0 &&
    se0_cnt_r == CNT_W'(RESET_CYC - 1);

  // traffic gate: after attach wait for the first bus reset
  logic seen_reset_r;
  always_ff @(posedge clk_sys) begin
    if (!nrst || !active) begin
      seen_reset_r <= 1'b0;
    end else if (reset_hit) begin
      seen_reset_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      traffic_enable <= 1'b0;
    end else begin
      traffic_enable <= active && seen_reset_r;
    end
  end

  // resistor change: weak while idle J, strong with activity
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pullup_strong <= 1'b0;
    end else begin
      pullup_strong <= active && bus_state != LS_J;
    end
  end

  // endpoints and address, reset by bus reset
  logic [31:0] ep_mask;
  logic [31:0] ep_dir_mask;
  assign ep_dir_mask = (32'h0000_0001 << EP_PER_DIR) - 32'h0000_0001;
  assign ep_mask = ep_dir_mask | (ep_dir_mask << EP_OUT_BASE);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ep_enable <= EP_ENABLE_RST;
      device_address <= ADDR_RST;
    end else if (reset_hit) begin
      ep_enable <= EP_CTRL_MASK;
      device_address <= ADDR_RST;
    end else begin
      if (wr_acc && paddr == ADDR_EP_ENABLE) begin
        ep_enable <= (pwdata & ep_mask) | EP_CTRL_MASK;
      end
      if (wr_acc && paddr == ADDR_DEV_ADDR) begin
        device_address <= pwdata[6:0];
      end
    end
  end

  // iso double buffer bank flips on each bank write with a one in its bit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      iso_in_bank <= 1'b0;
      iso_out_bank <= 1'b0;
    end else if (wr_acc && paddr == ADDR_EP_INFO) begin
      iso_in_bank <= iso_in_bank ^ pwdata[0];
      iso_out_bank <= iso_out_bank ^ pwdata[1];
    end
  end

  // line forcing
  logic [1:0] force_val_r;
  ufb_force_type force_cap_r;
  logic forcing_r;
  logic [CNT_W-1:0] resume_cnt_r;
  logic do_force;
  logic do_release;
  assign do_force = wr_acc && paddr == ADDR_TASK && pwdata[TASK_FORCE_BIT];
  assign do_release = wr_acc && paddr == ADDR_TASK && pwdata[TASK_RELEASE_BIT];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      force_val_r <= 2'h0;
    end else if (wr_acc && paddr == ADDR_FORCE_VAL) begin
      force_val_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      forcing_r <= 1'b0;
      force_cap_r <= FV_RESUME;
      resume_cnt_r <= '0;
    end else if (do_release || !live) begin
      forcing_r <= 1'b0;
    end else if (do_force) begin
      forcing_r <= 1'b1;
      force_cap_r <= ufb_force_type'(force_val_r);
      resume_cnt_r <= '0;
    end else if (forcing_r && force_cap_r == FV_RESUME) begin
      if (resume_cnt_r == CNT_W'(RESUME_CYCLES - 1)) begin
        forcing_r <= 1'b0;
      end else begin
        resume_cnt_r <= resume_cnt_r + 1'b1;
      end
    end
  end

  // full speed only: no chirp path, device only drives J/K
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dpdm_oe <= 1'b0;
      dp_out <= 1'b0;
      dm_out <= 1'b0;
    end else begin
      dpdm_oe <= forcing_r && live;
      dp_out <= force_cap_r == FV_J;
      dm_out <= force_cap_r != FV_J;
    end
  end

  // events, set wins over write-one-to-clear
  logic [EV_W-1:0] events_r;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic ready_seen_r;
  always_comb begin
    ev_set = '0;
    ev_set[EV_BUS_RESET] = reset_hit;
    ev_set[EV_ACCESS_FAULT] = pullup_acc && !enable_r;
    ev_set[EV_PWR_READY] = live && settle_cnt_r == CNT_W'(SETTLE_CYC - 1) && !pwr_ready_r;
    ev_set[EV_BUS_READY] = pwr_ready_r && !ready_seen_r;
    ev_clr = (wr_acc && paddr == ADDR_EVENTS) ? pwdata[EV_W-1:0] : '0;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !live) begin
      ready_seen_r <= 1'b0;
    end else if (pwr_ready_r) begin
      ready_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      events_r <= '0;
    end else begin
      events_r <= (events_r & ~ev_clr) | ev_set;
    end
  end

  // read mux
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_ENABLE: rdata[0] = enable_r;
      ADDR_PULLUP: rdata[0] = pullup_r;
      ADDR_FORCE_VAL: rdata[1:0] = force_val_r;
      ADDR_STATUS: rdata = {24'h0, 1'b0, forcing_r, traffic_enable, pwr_ready_r,
        vbus_valid, enable_r, bus_state};
      ADDR_EVENTS: rdata[EV_W-1:0] = events_r;
      ADDR_DEV_ADDR: rdata[6:0] = device_address;
      ADDR_EP_ENABLE: rdata = ep_enable;
      ADDR_EP_INFO: rdata = {3'h0, ISO_BUF_BYTES, 5'h0, BULK_BUF_BYTES,
        iso_out_bank, iso_in_bank};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // zero wait state: ready in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

endmodule
`default_nettype wire

// ### sim/ufb_host_model.sv
/*
  Behavioural full-speed host at the far end of the D+/D- pair.
  Assumes the bench steers host drive by non-blocking writes after clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ufb_host_model (
  // device side
  input wire logic pullup_on,
  input wire logic dpdm_oe,
  input wire logic dp_out,
  input wire logic dm_out,
  // host drive
  input wire logic host_drv,
  input wire logic [1:0] host_lines,
  // resolved bus levels
  output logic dp,
  output logic dm
);
  always_comb begin
    if (dpdm_oe) {dp, dm} = {dp_out, dm_out};
    else if (host_drv) {dp, dm} = host_lines;
    // undriven: pull-up against host pull-downs, SE0 once detached
    else {dp, dm} = {pullup_on, 1'b0};
  end
endmodule
`default_nettype wire

// ### sim/ufb_frontend_monitor.sv
/*
  Concurrent checks on the bus front end top-level ports.
  Assumes one clk_sys domain and synchronous active-low nrst.
*/
`timescale 1ns/1ps
`default_nettype none
module ufb_frontend_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ufb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // watched signals
  input wire logic vbus_valid,
  input wire logic pullup_on,
  input wire logic phy_power_on,
  input wire logic traffic_enable,
  input wire logic dpdm_oe,
  input wire logic [31:0] ep_enable,
  input wire logic access_fault_event
);
  import ufb_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic acc;
  // lines are only driven with supply present as well as enable
  assign acc = psel && penable && pwrite && paddr == ADDR_TASK && phy_power_on && vbus_valid;
  property p_pull_vbus; pullup_on |-> $past(vbus_valid); endproperty
  property p_pull_pwr; pullup_on |-> phy_power_on; endproperty
  property p_rst; $rose(nrst) |-> !pullup_on && !dpdm_oe && !traffic_enable; endproperty
  property p_traffic; traffic_enable |-> pullup_on; endproperty
  property p_fault;
    access_fault_event |-> $past(psel && penable && paddr == ADDR_PULLUP) ##1 !access_fault_event;
  endproperty
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  property p_ctrl_ep; (ep_enable & EP_CTRL_MASK) == EP_CTRL_MASK; endproperty
  property p_force; acc && pwdata[TASK_FORCE_BIT] |-> ##[1:3] dpdm_oe; endproperty
  property p_release;
    acc && pwdata[TASK_RELEASE_BIT] && !pwdata[TASK_FORCE_BIT] |-> ##[1:3] !dpdm_oe;
  endproperty
  a_pull_vbus: assert property (p_pull_vbus)
    else $error("pull-up on without supply");
  a_pull_pwr: assert property (p_pull_pwr)
    else $error("pull-up on with transceiver off");
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
  a_traffic: assert property (p_traffic)
    else $error("traffic enabled while detached");
  a_fault: assert property (p_fault)
    else $error("fault pulse without pull-up access");
  a_ready: assert property (p_ready)
    else $error("apb answer timing wrong");
  a_ctrl_ep: assert property (p_ctrl_ep)
    else $error("control endpoints disabled");
  a_force: assert property (p_force)
    else $error("force task did not drive lines");
  a_release: assert property (p_release)
    else $error("release task did not free lines");
  c_attach: cover property ($rose(traffic_enable));
  c_force: cover property ($rose(dpdm_oe));
  c_fault: cover property (access_fault_event);
endmodule
bind ufb_frontend ufb_frontend_monitor mon (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .vbus_valid(vbus_valid), .pullup_on(pullup_on), .phy_power_on(phy_power_on),
  .traffic_enable(traffic_enable), .dpdm_oe(dpdm_oe), .ep_enable(ep_enable),
  .access_fault_event(access_fault_event));
`default_nettype wire

// ### sim/ufb_frontend_tb.sv
/*
  Self-checking bench for the bus front end, with an APB master and host model.
  Assumes short count parameters; checks use package constants and literal values.
*/
`timescale 1ns/1ps
`default_nettype none
module ufb_frontend_tb;
  import ufb_pkg::*;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, vbus_valid = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, ep_enable;
  logic pready, pslverr, perr, dp_in, dm_in, dp_out, dm_out, dpdm_oe, phy_power_on;
  logic pullup_on, pullup_strong, traffic_enable, iso_in_bank, iso_out_bank, access_fault_event;
  logic host_drv = 0;
  logic [1:0] host_lines = 2'b00;
  logic [6:0] device_address;
  int fails = 0, total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  ufb_frontend #(.RESET_CYC(4), .SETTLE_CYC(4), .RESUME_CYCLES(8)) dut (.clk_sys(clk_sys),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbus_valid(vbus_valid), .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out),
    .dpdm_oe(dpdm_oe), .phy_power_on(phy_power_on), .pullup_on(pullup_on),
    .pullup_strong(pullup_strong), .traffic_enable(traffic_enable), .ep_enable(ep_enable),
    .device_address(device_address), .iso_in_bank(iso_in_bank), .iso_out_bank(iso_out_bank),
    .access_fault_event(access_fault_event));
  ufb_host_model host (.pullup_on(pullup_on), .dpdm_oe(dpdm_oe), .dp_out(dp_out),
    .dm_out(dm_out), .host_drv(host_drv), .host_lines(host_lines), .dp(dp_in), .dm(dm_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no answer time assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic t_start;
    apb(0, ADDR_PULLUP, 0);
    chk(rd, 0);
    apb(1, ADDR_PULLUP, 1);
    apb(0, ADDR_EVENTS, 0);
    chk(rd[EV_ACCESS_FAULT], 1);
    chk(pullup_on, 0);
    vbus_valid <= 1'b1;
    tick(2);
    apb(1, ADDR_ENABLE, 1);
    tick(2);
    chk(phy_power_on, 1);
    tick(10);
    apb(0, ADDR_EVENTS, 0);
    chk(rd[3:2], 2'b11);
    apb(1, ADDR_EVENTS, 32'hf);
    apb(1, ADDR_PULLUP, 1);
    tick(3);
    chk(pullup_on, 1);
    apb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b10);
    chk(pullup_strong, 0);
    chk(traffic_enable, 0);
    $display("test start done");
  endtask
  task automatic t_lines;
    apb(1, ADDR_DEV_ADDR, 32'h5);
    apb(0, ADDR_DEV_ADDR, 0);
    chk(rd, 32'h5);
    // all ones: only the nine endpoints per direction may stick
    apb(1, ADDR_EP_ENABLE, 32'hffffffff);
    apb(0, ADDR_EP_ENABLE, 0);
    chk(rd, 32'h01ff01ff);
    host_drv <= 1'b1;
    host_lines <= 2'b01;
    tick(4);
    apb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b01);
    chk(pullup_strong, 1);
    host_lines <= 2'b11;
    tick(4);
    apb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b11);
    host_lines <= 2'b00;
    tick(4);
    apb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b00);
    tick(8);
    host_drv <= 1'b0;
    tick(4);
    chk(traffic_enable, 1);
    chk(device_address, 0);
    chk(ep_enable, EP_CTRL_MASK);
    apb(0, ADDR_EVENTS, 0);
    chk(rd[EV_BUS_RESET], 1);
    $display("test lines done");
  endtask
  task automatic t_detach;
    apb(1, ADDR_EVENTS, 32'hf);
    apb(1, ADDR_PULLUP, 0);
    tick(20);
    chk(pullup_on, 0);
    chk(traffic_enable, 0);
    apb(0, ADDR_EVENTS, 0);
    chk(rd[EV_BUS_RESET], 0);
    $display("test detach done");
  endtask
  task automatic t_force;
    apb(1, ADDR_FORCE_VAL, 32'(FV_K));
    apb(1, ADDR_TASK, 1);
    tick(2);
    chk({dpdm_oe, dp_out, dm_out}, 3'b101);
    apb(1, ADDR_FORCE_VAL, 32'(FV_J));
    tick(2);
    chk({dp_out, dm_out}, 2'b01);
    apb(1, ADDR_TASK, 2);
    tick(3);
    chk(dpdm_oe, 0);
    apb(1, ADDR_FORCE_VAL, 32'(FV_RESUME));
    apb(1, ADDR_TASK, 1);
    tick(2);
    chk({dpdm_oe, dp_out, dm_out}, 3'b101);
    // resume K is hardware timed and must end without a release
    tick(20);
    chk(dpdm_oe, 0);
    $display("test force done");
  endtask
  task automatic t_info;
    apb(0, ADDR_EP_INFO, 0);
    chk(rd[12:2], BULK_BUF_BYTES);
    chk(rd[28:18], ISO_BUF_BYTES);
    apb(1, ADDR_EP_INFO, 3);
    chk({iso_in_bank, iso_out_bank}, 2'b11);
    apb(1, 12'h0fc, 1);
    chk(perr, 1);
    apb(0, 12'h0fc, 0);
    chk(rd, 0);
    $display("test info done");
  endtask
  task automatic t_remove;
    apb(1, ADDR_PULLUP, 1);
    tick(3);
    chk(pullup_on, 1);
    vbus_valid <= 1'b0;
    tick(3);
    chk(pullup_on, 0);
    // no buffer transfers are in flight, so disabling at once is safe
    apb(1, ADDR_ENABLE, 0);
    tick(2);
    chk(phy_power_on, 0);
    $display("test remove done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(12);
    nrst <= 1'b1;
    tick(1);
    t_start;
    t_lines;
    t_detach;
    t_force;
    t_info;
    t_remove;
    tally_and_finish;
  end
  initial begin
    #100000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule
`default_nettype wire
